// ===== rtl/dcm_ddr2_ctrl.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - Precharge-all always precedes every autorefresh
// - Autorefresh repeats at refresh_interval link cycles
// - Page table cleared before and after refresh
// - Refresh cannot be disabled by software
// - Precharge-all after reset, init, before mode writes
// - Address bit 10 high during precharge-all
// - Single precharge closes only selected bank
// - Activate closed row: bank and row driven
// - Wait row-to-column delay after activate
// - Read: cas low, ras/we high, column
// - Burst 8, CAS latency 2 to 5
// - Additive latency programmed as zero
// - Read burst runs eight beats, extras dropped
// - Rows stay open until page invalid
// - Write data starts CAS latency minus one
// - Write burst eight beats, unused beats masked
// - Mode writes: select on bank bits, value
// - Mode writes only inside the init sequence
// - x16 or x32, little endian, low lanes
// - bank_count_sel gives 1, 2, 4, 8 banks
// - page_words_sel gives 8 to 11 column bits
// - Thirteen row bits, row/column share pins
// - Column lowest, bank above, then row
module dcm_ddr2_ctrl
  import dcm_pkg::*;
#(
  parameter int CLK_HALF   = CLK_HALF_DEF,
  parameter int INIT_TICKS = INIT_TICKS_DEF
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // AXI4-Lite slave
  input  wire logic [7:0]   s_axi_awaddr_i,
  input  wire logic         s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  wire logic [31:0]  s_axi_wdata_i,
  input  wire logic [3:0]   s_axi_wstrb_i,
  input  wire logic         s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  wire logic         s_axi_bready_i,
  input  wire logic [7:0]   s_axi_araddr_i,
  input  wire logic         s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  wire logic         s_axi_rready_i,
  // Requester port
  input  wire dcm_req_t     req_i,
  input  wire logic         req_valid_i,
  output logic              req_ready_o,
  output logic              rsp_valid_o,
  output logic [31:0]       rsp_rdata_o,
  // Memory pins
  output logic              ddr_clk_o,
  output logic              ddr_cke_o,
  output dcm_ddr_ctl_t      ddr_ctl_o,
  input  wire logic [31:0]  ddr_dq_i,
  output logic [31:0]       ddr_dq_o,
  output logic              ddr_dq_oe_o,
  output logic [3:0]        ddr_dqm_o
);

  typedef enum logic [3:0] {
    ST_INIT, ST_INIT_PALL, ST_EXT_MODE_REG_WRITE_CMD, ST_MRS, ST_POST_PALL, ST_IDLE, ST_REF_PALL,
    ST_REFRESH, ST_PRE_ONE, ST_ACTIVATE, ST_ACCESS, ST_DATA, ST_WAIT
  } dcm_state_t;

  // ==========================================================================
  // Address split: column lowest, then bank, then 13 row bits
  function automatic dcm_map_t dcm_split(input logic [31:0] a, input logic [1:0] pg,
                                         input logic [1:0] bk, input logic narrow);
    logic [31:0] w;
    logic [4:0]  ncb;
    logic [4:0]  nbb;
    dcm_map_t    m;
    w   = narrow ? (a >> 1) : (a >> 2);
    ncb = 5'h8 + {3'h0, pg};
    nbb = {3'h0, bk};
    m.col  = 11'(w & ((32'h1 << ncb) - 32'h1));
    w      = w >> ncb;
    m.bank = 3'(w & ((32'h1 << nbb) - 32'h1));
    w      = w >> nbb;
    m.row  = w[ROW_BITS-1:0];
    return m;
  endfunction

  // ==========================================================================
  // Registers and state
  logic [31:0]  bank_cfg;
  logic [31:0]  ref_ctrl;
  logic [31:0]  timing;
  logic         cfg_restart;
  dcm_state_t   state;
  dcm_state_t   after_state;
  logic [7:0]   wait_cnt;
  logic [15:0]  init_cnt;
  logic         init_done;
  logic [12:0]  ref_cnt;
  logic         ref_due;
  logic [7:0]   bank_open;
  logic [12:0]  open_row [8];
  logic         pend;
  dcm_req_t     req_q;
  dcm_map_t     map_q;
  logic [3:0]   lat_cnt;
  logic [3:0]   beat;
  logic [31:0]  rd_word;
  logic [7:0]   half_cnt;
  logic [31:0]  dq_meta;
  logic [31:0]  dq_sync;

  // ==========================================================================
  // Field decode
  wire  [1:0]  page_words_sel = bank_cfg[PAGE_LSB +: 2];
  wire  [1:0]  bank_count_sel = bank_cfg[BANK_LSB +: 2];
  wire  [2:0]  cas_lat        = bank_cfg[CL_LSB +: 3];
  wire         narrow         = bank_cfg[NARROW_BIT];
  wire  [12:0] refresh_interval = ref_ctrl[12:0];
  wire  [7:0]  t_rcd  = {4'h0, timing[TRCD_LSB +: 4]};
  wire  [7:0]  t_rp   = {4'h0, timing[TRP_LSB +: 4]};
  wire  [7:0]  t_rfc  = timing[TRFC_LSB +: 8];
  wire  [7:0]  t_wr   = {4'h0, timing[TWR_LSB +: 4]};
  wire  [12:0] ref_limit  = (refresh_interval == 13'h0) ? 13'h1 : refresh_interval;
  wire         row_hit    = bank_open[map_q.bank] && (open_row[map_q.bank] == map_q.row);
  wire  [12:0] col_pins   = {1'b0, map_q.col[10], 1'b0, map_q.col[9:0]};  // A10 low
  wire  [12:0] mr_value   = {6'h00, cas_lat, 1'b0, MR_BL8};
  wire         last_beat  = (beat == BURST_LEN - 4'h1);
  wire  [3:0]  word_beats = narrow ? 4'h2 : 4'h1;

  // ==========================================================================
  // Link clock divider; tick marks each rising edge of the memory clock
  wire half_end = (half_cnt == 8'(CLK_HALF - 1));
  wire tick     = half_end & ~ddr_clk_o;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      half_cnt  <= 8'h00;
      ddr_clk_o <= 1'b0;
    end else if (half_end) begin
      half_cnt  <= 8'h00;
      ddr_clk_o <= ~ddr_clk_o;
    end else begin
      half_cnt  <= half_cnt + 8'h01;
    end
  end

  // Read data pins cross two flops before use
  always_ff @(posedge sys_clk_i) begin
    dq_meta <= ddr_dq_i;
    dq_sync <= dq_meta;
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_fire  = s_axi_awvalid_i & s_axi_awready_o;
  wire w_fire   = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_go    = aw_hold & w_hold & ~s_axi_bvalid_o;
  wire wr_cfg   = wr_go & (aw_addr == OFS_BANK_CFG);
  wire wr_ref   = wr_go & (aw_addr == OFS_REF_CTRL);
  wire wr_tim   = wr_go & (aw_addr == OFS_TIMING);
  wire wr_ok    = wr_cfg | wr_ref | wr_tim | (aw_addr == OFS_STATUS);
  wire ar_fire  = s_axi_arvalid_i & s_axi_arready_o;

  assign s_axi_awready_o = ~aw_hold;
  assign s_axi_wready_o  = ~w_hold;
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] dcm_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  wire [31:0] cfg_merged = dcm_merge(bank_cfg, w_data, w_strb);
  wire [2:0]  cl_new     = cfg_merged[CL_LSB +: 3];
  wire        cl_legal   = (cl_new >= CL_MIN) && (cl_new <= CL_MAX);
  wire [31:0] status_word = {16'h0000, bank_open, 5'h00, pend, ref_due, init_done};

  // Address and data latch until both halves of a write have arrived
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr_i[7:2], 2'b00};
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (w_fire) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
    end
  end

  // Register writes and bus answers; an illegal CAS latency keeps the old one
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bank_cfg       <= BANK_CFG_RST;
      ref_ctrl       <= REF_CTRL_RST;
      timing         <= TIMING_RST;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= 2'b00;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= 2'b00;
      s_axi_rdata_o  <= 32'h0000_0000;
    end else begin
      if (wr_cfg) begin
        bank_cfg <= cl_legal ? cfg_merged : {cfg_merged[31:12], cas_lat, cfg_merged[8:0]};
      end
      if (wr_ref) ref_ctrl <= dcm_merge(ref_ctrl, w_data, w_strb);
      if (wr_tim) timing <= dcm_merge(timing, w_data, w_strb);
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (ar_fire) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= 2'b00;
        unique case ({s_axi_araddr_i[7:2], 2'b00})
          OFS_STATUS:   s_axi_rdata_o <= status_word;
          OFS_BANK_CFG: s_axi_rdata_o <= bank_cfg;
          OFS_REF_CTRL: s_axi_rdata_o <= ref_ctrl;
          OFS_TIMING:   s_axi_rdata_o <= timing;
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= 2'b10;
          end
        endcase
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Requester side: one request latched at a time
  assign req_ready_o = ~pend & init_done;
  wire   req_take    = req_valid_i & req_ready_o;
  wire   req_done    = tick & (state == ST_DATA) & last_beat & (lat_cnt <= 4'h1);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pend  <= 1'b0;
      req_q <= '0;
      map_q <= '0;
    end else if (req_take) begin
      pend  <= 1'b1;
      req_q <= req_i;
      map_q <= dcm_split(req_i.addr, page_words_sel, bank_count_sel, narrow);
    end else if (req_done) begin
      pend  <= 1'b0;
    end
  end

  // Refresh interval counter runs on link cycles and never stops
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ref_cnt <= 13'h0000;
      ref_due <= 1'b0;
    end else if (tick) begin
      if (ref_cnt >= ref_limit - 13'h1) begin
        ref_cnt <= 13'h0000;
        ref_due <= 1'b1;
      end else begin
        ref_cnt <= ref_cnt + 13'h0001;
        if (state == ST_REFRESH) ref_due <= 1'b0;
      end
    end
  end

  // A new bank configuration reruns init once the bus is quiet
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_restart <= 1'b0;
    end else if (wr_cfg) begin
      cfg_restart <= 1'b1;
    end else if (state == ST_INIT) begin
      cfg_restart <= 1'b0;
    end
  end

  // ==========================================================================
  // Command sequencer; every command is issued on a link tick
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state       <= ST_INIT;
      after_state <= ST_IDLE;
      wait_cnt    <= 8'h00;
      init_cnt    <= 16'h0000;
      init_done   <= 1'b0;
      bank_open   <= 8'h00;
      ddr_ctl_o   <= {CMD_NOP, 3'h0, 13'h0000};
      ddr_cke_o   <= 1'b0;
      lat_cnt     <= 4'h0;
      beat        <= 4'h0;
    end else if (tick) begin
      ddr_ctl_o.cmd <= CMD_NOP;
      unique case (state)
        ST_INIT: begin
          init_done <= 1'b0;
          ddr_cke_o <= 1'b1;
          if (init_cnt >= 16'(INIT_TICKS)) begin
            init_cnt <= 16'h0000;
            state    <= ST_INIT_PALL;
          end else begin
            init_cnt <= init_cnt + 16'h0001;
          end
        end
        ST_INIT_PALL, ST_POST_PALL, ST_REF_PALL: begin
          ddr_ctl_o   <= {CMD_PRE, 3'h0, 13'h0400};
          bank_open   <= 8'h00;
          wait_cnt    <= t_rp;
          after_state <= (state == ST_INIT_PALL) ? ST_EXT_MODE_REG_WRITE_CMD :
                         (state == ST_REF_PALL)  ? ST_REFRESH : ST_IDLE;
          if (state == ST_POST_PALL) init_done <= 1'b1;
          state       <= ST_WAIT;
        end
        ST_EXT_MODE_REG_WRITE_CMD: begin
          ddr_ctl_o   <= {CMD_MRS, EMR_SEL, EMR_VALUE};
          wait_cnt    <= t_rp;
          after_state <= ST_MRS;
          state       <= ST_WAIT;
        end
        ST_MRS: begin
          ddr_ctl_o   <= {CMD_MRS, MR_SEL, mr_value};
          wait_cnt    <= t_rp;
          after_state <= ST_POST_PALL;
          state       <= ST_WAIT;
        end
        ST_IDLE: begin
          if (cfg_restart) begin
            state <= ST_INIT;
          end else if (ref_due) begin
            state <= ST_REF_PALL;
          end else if (pend) begin
            if (row_hit) state <= ST_ACCESS;
            else if (bank_open[map_q.bank]) state <= ST_PRE_ONE;
            else state <= ST_ACTIVATE;
          end
        end
        ST_REFRESH: begin
          ddr_ctl_o   <= {CMD_REF, 3'h0, 13'h0000};
          bank_open   <= 8'h00;
          wait_cnt    <= t_rfc;
          after_state <= ST_IDLE;
          state       <= ST_WAIT;
        end
        ST_PRE_ONE: begin
          ddr_ctl_o   <= {CMD_PRE, map_q.bank, 13'h0000};
          bank_open[map_q.bank] <= 1'b0;
          wait_cnt    <= t_rp;
          after_state <= ST_ACTIVATE;
          state       <= ST_WAIT;
        end
        ST_ACTIVATE: begin
          ddr_ctl_o   <= {CMD_ACT, map_q.bank, map_q.row};
          bank_open[map_q.bank] <= 1'b1;
          wait_cnt    <= t_rcd;
          after_state <= ST_ACCESS;
          state       <= ST_WAIT;
        end
        ST_ACCESS: begin
          ddr_ctl_o <= {(req_q.write ? CMD_WR : CMD_RD), map_q.bank, col_pins};
          lat_cnt   <= req_q.write ? 4'(cas_lat - 3'h1) : 4'(cas_lat + 3'h1);
          beat      <= 4'h0;
          state     <= ST_DATA;
        end
        ST_DATA: begin
          if (lat_cnt > 4'h1) begin
            lat_cnt <= lat_cnt - 4'h1;
          end else if (last_beat) begin
            wait_cnt    <= req_q.write ? t_wr : 8'h01;
            after_state <= ST_IDLE;
            state       <= ST_WAIT;
          end else begin
            beat <= beat + 4'h1;
          end
        end
        ST_WAIT: begin
          if (wait_cnt <= 8'h01) state <= after_state;
          else wait_cnt <= wait_cnt - 8'h01;
        end
        default: state <= ST_INIT;
      endcase
    end
  end

  // Row table follows each activate
  always_ff @(posedge sys_clk_i) begin
    if (tick && state == ST_ACTIVATE) open_row[map_q.bank] <= map_q.row;
  end

  // ==========================================================================
  // Data lanes: x16 parts sit on the low lanes, low half first
  wire data_beat = tick && (state == ST_DATA) && (lat_cnt <= 4'h1);
  wire word_beat = data_beat && (beat < word_beats);
  wire [3:0] lane_mask = narrow ? ~{2'b00, (beat == 4'h0) ? req_q.be[1:0] : req_q.be[3:2]}
                                : ~req_q.be;

  // Write beats beyond the word are masked rather than cut short
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ddr_dq_o    <= 32'h0000_0000;
      ddr_dq_oe_o <= 1'b0;
      ddr_dqm_o   <= 4'hF;
    end else if (data_beat && req_q.write && !(last_beat && ddr_dq_oe_o && beat != 4'h7)) begin
      ddr_dq_oe_o <= 1'b1;
      ddr_dq_o    <= (narrow && beat == 4'h1) ? {16'h0000, req_q.wdata[31:16]} : req_q.wdata;
      ddr_dqm_o   <= (beat < word_beats) ? lane_mask : 4'hF;
    end else if (tick && state != ST_DATA) begin
      ddr_dq_oe_o <= 1'b0;
      ddr_dqm_o   <= 4'hF;
    end
  end

  // Read capture keeps the word's beats and drops the rest of the burst
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_word     <= 32'h0000_0000;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 32'h0000_0000;
    end else begin
      rsp_valid_o <= req_done;
      if (word_beat && !req_q.write) begin
        if (narrow && beat == 4'h1) rd_word[31:16] <= dq_sync[15:0];
        else if (narrow) rd_word[15:0] <= dq_sync[15:0];
        else rd_word <= dq_sync;
      end
      if (req_done) begin
        rsp_rdata_o <= req_q.write ? 32'h0000_0000 : rd_word;
      end
    end
  end

endmodule

// ===== include/dcm_pkg.sv
package dcm_pkg;

  // ==========================================================================
  // Register map, byte addresses on the AXI4-Lite bus
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_BANK_CFG = 8'h04;
  localparam logic [7:0] OFS_REF_CTRL = 8'h08;
  localparam logic [7:0] OFS_TIMING   = 8'h0C;

  // ==========================================================================
  // Field positions
  localparam int PAGE_LSB   = 0;   // page_words_sel [1:0]
  localparam int BANK_LSB   = 4;   // bank_count_sel [5:4]
  localparam int CL_LSB     = 9;   // CAS latency [11:9]
  localparam int NARROW_BIT = 14;  // 1: x16 memory, 0: x32 memory
  localparam int TRCD_LSB   = 0;   // timing [3:0]
  localparam int TRP_LSB    = 4;   // timing [7:4]
  localparam int TRFC_LSB   = 8;   // timing [15:8]
  localparam int TWR_LSB    = 16;  // timing [19:16]

  // ==========================================================================
  // Reset values
  localparam logic [31:0] BANK_CFG_RST = 32'h0000_0632;  // CL 3, 8 banks, 1024 words
  localparam logic [31:0] REF_CTRL_RST = 32'h0000_0100;  // refresh_interval in link cycles
  localparam logic [31:0] TIMING_RST   = 32'h0002_1A33;

  // ==========================================================================
  // Memory constants
  localparam logic [3:0]  BURST_LEN  = 4'h8;
  localparam int          ROW_BITS   = 13;
  localparam logic [2:0]  CL_MIN     = 3'h2;
  localparam logic [2:0]  CL_MAX     = 3'h5;
  localparam logic [2:0]  MR_BL8     = 3'h3;
  localparam int          MR_CL_LSB  = 4;
  localparam logic [12:0] EMR_VALUE  = 13'h0000;  // additive latency 0
  localparam logic [2:0]  MR_SEL     = 3'h0;
  localparam logic [2:0]  EMR_SEL    = 3'h1;
  localparam int          CLK_HALF_DEF   = 10;    // sys cycles per half link period
  localparam int          INIT_TICKS_DEF = 200;   // link cycles of idle clock at start

  // ==========================================================================
  // Command encoding {cs_n, ras_n, cas_n, we_n}
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dcm_cmd_t;

  localparam dcm_cmd_t CMD_NOP = 4'h7;
  localparam dcm_cmd_t CMD_ACT = 4'h3;
  localparam dcm_cmd_t CMD_PRE = 4'h2;
  localparam dcm_cmd_t CMD_REF = 4'h1;
  localparam dcm_cmd_t CMD_MRS = 4'h0;
  localparam dcm_cmd_t CMD_RD  = 4'h5;
  localparam dcm_cmd_t CMD_WR  = 4'h4;

  typedef struct packed {
    dcm_cmd_t    cmd;
    logic [2:0]  bank_sel;
    logic [12:0] addr;
  } dcm_ddr_ctl_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } dcm_req_t;

  typedef struct packed {
    logic [12:0] row;
    logic [2:0]  bank;
    logic [10:0] col;
  } dcm_map_t;

endpackage

// ===== tb/dcm_ddr2_ctrl_props.sv
`timescale 1ns/1ps
module dcm_ddr2_ctrl_props
  import dcm_pkg::*;
#(
  parameter int CLK_HALF = CLK_HALF_DEF
) (
  // Clock and reset
  input wire logic         sys_clk_i,
  input wire logic         rst_i,
  // Requester and memory commands
  input wire logic         req_valid_i,
  input wire logic         req_ready_o,
  input wire dcm_ddr_ctl_t ddr_ctl_o
);
  // Shortest legal activate-to-access spacing in sys cycles
  localparam int GAP = 4 * CLK_HALF - 2;
  dcm_cmd_t    cmd;
  logic        rw;
  logic        pall;
  logic [7:0]  open_q;
  logic        pall_q;
  logic [15:0] gap_q;
  assign cmd  = ddr_ctl_o.cmd;
  assign rw   = (cmd == CMD_RD) || (cmd == CMD_WR);
  assign pall = (cmd == CMD_PRE) && ddr_ctl_o.addr[10];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Bank state as the memory sees it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      open_q <= 8'h00;
      pall_q <= 1'b0;
      gap_q  <= 16'hFFFF;
    end else begin
      if (cmd == CMD_ACT) begin
        open_q[ddr_ctl_o.bank_sel] <= 1'b1;
      end else if (pall || cmd == CMD_REF) begin
        open_q <= 8'h00;
      end else if (cmd == CMD_PRE) begin
        open_q[ddr_ctl_o.bank_sel] <= 1'b0;
      end
      pall_q <= pall || (pall_q && cmd != CMD_ACT);
      gap_q  <= (cmd == CMD_ACT) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
    end
  end
  // ==========
  // Command rules
  a_ref_after_pall: assert property (cmd == CMD_REF |-> pall_q && open_q == 8'h00)
    else $error("refresh without precharge-all");
  a_mode_after_pall: assert property (cmd == CMD_MRS |-> pall_q && open_q == 8'h00)
    else $error("mode write without precharge-all");
  a_rw_row_open: assert property (rw |-> open_q[ddr_ctl_o.bank_sel])
    else $error("access to closed row");
  a_trcd_gap: assert property (rw |-> gap_q >= GAP)
    else $error("row-to-column delay short");
  a_rw_a10_low: assert property (rw |-> !ddr_ctl_o.addr[10])
    else $error("address bit 10 high on access");
  a_mode_init_only: assert property (cmd == CMD_MRS |-> !req_ready_o)
    else $error("mode write outside init");
  a_mode_fields: assert property (cmd == CMD_MRS |-> (ddr_ctl_o.bank_sel == EMR_SEL &&
    ddr_ctl_o.addr == EMR_VALUE) || (ddr_ctl_o.bank_sel == MR_SEL && ddr_ctl_o.addr[2:0] == MR_BL8))
    else $error("bad mode write");
  a_one_accept: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("second request accepted");
  c_refresh: cover property (cmd == CMD_REF);
  c_read: cover property (cmd == CMD_RD);
  c_write: cover property (cmd == CMD_WR);
endmodule

bind dcm_ddr2_ctrl dcm_ddr2_ctrl_props #(.CLK_HALF(CLK_HALF)) u_props (
  .sys_clk_i   (sys_clk_i),
  .rst_i       (rst_i),
  .req_valid_i (req_valid_i),
  .req_ready_o (req_ready_o),
  .ddr_ctl_o   (ddr_ctl_o)
);

// ===== tb/dcm_mem_model.sv
`timescale 1ns/1ps
module dcm_mem_model
  import dcm_pkg::*;
(
  // Clocks
  input  wire logic         sys_clk_i,
  input  wire logic         ddr_clk_i,
  // Controller pins
  input  wire dcm_ddr_ctl_t ddr_ctl_i,
  input  wire logic [31:0]  dq_i,
  input  wire logic         dq_oe_i,
  input  wire logic [3:0]   dqm_i,
  output logic [31:0]       dq_o
);
  logic [31:0] mem [logic [26:0]];
  logic [12:0] row_q [8];
  logic [26:0] cur_k, rd_k, wr_k;
  logic        clk_q = 1'b0;
  int          cl = 3;
  int          tick_n = 0;
  int          rd_t = -99;
  int          wr_t = -99;
  int          ref_n = 0;
  // Column sits on A11 and A9..A0, A10 is the precharge flag
  assign cur_k = {ddr_ctl_i.bank_sel, row_q[ddr_ctl_i.bank_sel], ddr_ctl_i.addr[11],
                  ddr_ctl_i.addr[9:0]};
  // Beat address wraps inside the aligned burst of eight
  function automatic logic [26:0] bk(input logic [26:0] k, input int t);
    return {k[26:3], k[2:0] + 3'(tick_n - t)};
  endfunction
  initial dq_o = 32'h0;
  // Work one system cycle after each rising link edge, when the pins have settled
  always @(posedge sys_clk_i) begin
    clk_q <= ddr_clk_i;
    if (ddr_clk_i && !clk_q) begin
      tick_n = tick_n + 1;
      case (ddr_ctl_i.cmd)
        CMD_ACT: row_q[ddr_ctl_i.bank_sel] = ddr_ctl_i.addr;
        CMD_REF: ref_n = ref_n + 1;
        CMD_MRS: if (ddr_ctl_i.bank_sel == MR_SEL) cl = int'(ddr_ctl_i.addr[6:4]);
        CMD_RD: begin
          rd_t = tick_n + cl;
          rd_k = cur_k;
        end
        CMD_WR: begin
          wr_t = tick_n + cl - 1;
          wr_k = cur_k;
        end
        default: ;
      endcase
      for (int i = 0; i < 4; i++) begin
        if (dq_oe_i && !dqm_i[i] && tick_n >= wr_t && tick_n < wr_t + 8) begin
          mem[bk(wr_k, wr_t)][8*i +: 8] = dq_i[8*i +: 8];
        end
      end
      // Released bus shows the inverse so stale data never matches
      dq_o <= (tick_n >= rd_t && tick_n < rd_t + 8) ? mem[bk(rd_k, rd_t)] : ~dq_o;
    end
  end
endmodule

// ===== tb/dcm_ddr2_ctrl_tb_top.sv
`timescale 1ns/1ps
module dcm_ddr2_ctrl_tb_top
  import dcm_pkg::*;
();
  // ==========
  // Signals named as the design ports
  logic         sys_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0;
  logic [7:0]   s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0]  s_axi_wdata_i = 32'h0, s_axi_rdata_o, rsp_rdata_o, ddr_dq_i, ddr_dq_o;
  logic [3:0]   s_axi_wstrb_i = 4'hF, ddr_dqm_o;
  logic         s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b1;
  logic         s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b1, s_axi_awready_o;
  logic         s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic         req_ready_o, rsp_valid_o, ddr_clk_o, ddr_cke_o, ddr_dq_oe_o;
  logic [1:0]   s_axi_bresp_o, s_axi_rresp_o;
  dcm_req_t     req_i = '0;
  dcm_ddr_ctl_t ddr_ctl_o;
  logic [31:0]  ref_m [logic [31:0]];
  int           num_errors = 0, check_count = 0, cyc = 0;

  always #4 sys_clk_i = ~sys_clk_i;
  dcm_ddr2_ctrl #(.INIT_TICKS(4)) DUT (.*);
  dcm_mem_model u_mem (
    .sys_clk_i (sys_clk_i),
    .ddr_clk_i (ddr_clk_o),
    .ddr_ctl_i (ddr_ctl_o),
    .dq_i      (ddr_dq_o),
    .dq_oe_i   (ddr_dq_oe_o),
    .dqm_i     (ddr_dqm_o),
    .dq_o      (ddr_dq_i)
  );

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Sampled at the rising edge; bready and rready stay high throughout
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      r = s_axi_bresp_o;
    end while (!s_axi_bvalid_o);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
    end while (!s_axi_rvalid_o);
  endtask
  task automatic mreq(input logic wr, input logic [31:0] a, d, input logic [3:0] be,
                      output logic [31:0] q);
    req_i       <= '{wr, a, d, be};
    req_valid_i <= 1'b1;
    do @(posedge sys_clk_i); while (!req_ready_o);
    req_valid_i <= 1'b0;
    req_i       <= ~req_i;
    do @(posedge sys_clk_i); while (!rsp_valid_o);
    q = rsp_rdata_o;
  endtask
  // Column lowest, bank above, thirteen row bits above that
  function automatic logic [26:0] mkey(input logic [31:0] a, input int bk, input int pg);
    logic [31:0] w;
    w = a >> 2;
    return {3'((w >> (8 + pg)) & ((1 << bk) - 1)), 13'(w >> (8 + pg + bk)),
            11'(w & ((1 << (8 + pg)) - 1))};
  endfunction
  // Cut a hang short
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end
  // ==========
  // Main sequence
  initial begin
    logic [31:0] a, b, d, q;
    logic [1:0]  r;
    int          n0;
    a = $urandom(32'h15ad);
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    axr(OFS_BANK_CFG, q, r);
    chk(q, BANK_CFG_RST);
    axr(OFS_TIMING, q, r);
    chk(q, TIMING_RST);
    axr(8'h10, q, r);
    chk({q[29:0], r}, 32'h2);
    axw(8'h10, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, 32'h2);
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      axw(OFS_BANK_CFG, 32'(((c + c / 4) % 4 + 2) << CL_LSB | (c / 4) << BANK_LSB | c % 4), r);
      chk({30'h0, r}, 32'h0);
      a = ($urandom | ((32'h1 << (10 + c % 4)) - 4)) & 32'h3FFF_FFFC;
      for (int k = 0; k < 3; k++) begin
        b = a + 32'(k % 2 * 4);
        d = $urandom;
        mreq(1'b1, b, d, (k == 2) ? 4'h3 : 4'hF, q);
        ref_m[b] = (k == 2) ? {ref_m[a][31:16], d[15:0]} : d;
        chk(u_mem.mem[mkey(b, c / 4, c % 4)], ref_m[b]);
      end
      for (int k = 0; k < 2; k++) begin
        mreq(1'b0, a + 32'(4 * k), 32'h0, 4'h0, q);
        chk(q, ref_m[a + 32'(4 * k)]);
      end
    end
    $display("test mapping done");
    axw(OFS_REF_CTRL, 32'h40, r);
    n0 = u_mem.ref_n;
    repeat (64 * 20 * 8) @(posedge sys_clk_i);
    chk(32'(u_mem.ref_n - n0 inside {[7:9]}), 32'h1);
    $display("test refresh done");
    results();
  end
endmodule
